// ==== cs_timer_pkg.sv ====
// constants for the cyclic sense and cyclic wake timer block
package cs_timer_pkg;
    localparam int          CLK_HZ        = 200_000_000;
    localparam int          TICK_US       = 100;
    localparam int          TICK_CYCLES   = CLK_HZ / 1_000_000 * TICK_US;
    localparam int          FILTER_US     = 16;
    localparam int          FILTER_CYCLES = CLK_HZ / 1_000_000 * FILTER_US;
    localparam int          CNT_W         = 16;
    localparam int          NUM_WAKE      = 3;
    localparam int          NUM_SWITCH    = 4;
    // period codes, in 0.1 ms ticks
    localparam logic [2:0]  PER_10MS      = 3'h0;
    localparam logic [2:0]  PER_20MS      = 3'h1;
    localparam logic [2:0]  PER_50MS      = 3'h2;
    localparam logic [2:0]  PER_100MS     = 3'h3;
    localparam logic [2:0]  PER_200MS     = 3'h4;
    localparam logic [2:0]  PER_1S        = 3'h5;
    localparam logic [2:0]  PER_2S        = 3'h6;
    localparam logic [15:0] TK_10MS       = 16'h0064;
    localparam logic [15:0] TK_20MS       = 16'h00C8;
    localparam logic [15:0] TK_50MS       = 16'h01F4;
    localparam logic [15:0] TK_100MS      = 16'h03E8;
    localparam logic [15:0] TK_200MS      = 16'h07D0;
    localparam logic [15:0] TK_1S         = 16'h2710;
    localparam logic [15:0] TK_2S         = 16'h4E20;
    // on-time codes
    localparam logic [2:0]  ON_OFF_LOW    = 3'h0;
    localparam logic [2:0]  ON_0P1MS      = 3'h1;
    localparam logic [2:0]  ON_0P3MS      = 3'h2;
    localparam logic [2:0]  ON_1MS        = 3'h3;
    localparam logic [2:0]  ON_10MS       = 3'h4;
    localparam logic [2:0]  ON_20MS       = 3'h5;
    localparam logic [2:0]  ON_OFF_HIGH   = 3'h6;
    localparam logic [15:0] TK_0P1MS      = 16'h0001;
    localparam logic [15:0] TK_0P3MS      = 16'h0003;
    localparam logic [15:0] TK_1MS        = 16'h000A;
    // device modes
    typedef enum logic [2:0] {
        MODE_NORMAL   = 3'h0,
        MODE_STOP     = 3'h1,
        MODE_SLEEP    = 3'h2,
        MODE_RESTART  = 3'h3,
        MODE_FAILSAFE = 3'h4
    } dev_mode_e;

    function automatic logic [15:0] period_ticks(input logic [2:0] code);
        case (code)
            PER_10MS:  period_ticks = TK_10MS;
            PER_20MS:  period_ticks = TK_20MS;
            PER_50MS:  period_ticks = TK_50MS;
            PER_100MS: period_ticks = TK_100MS;
            PER_200MS: period_ticks = TK_200MS;
            PER_1S:    period_ticks = TK_1S;
            default:   period_ticks = TK_2S;
        endcase
    endfunction

    function automatic logic [15:0] on_ticks(input logic [2:0] code);
        case (code)
            ON_0P1MS: on_ticks = TK_0P1MS;
            ON_0P3MS: on_ticks = TK_0P3MS;
            ON_1MS:   on_ticks = TK_1MS;
            ON_10MS:  on_ticks = TK_10MS;
            ON_20MS:  on_ticks = TK_20MS;
            default:  on_ticks = 16'h0000;
        endcase
    endfunction
endpackage

// ==== cs_periodic_timer.sv ====
// one periodic timer with selectable period and on-time
`timescale 1ns/1ps
module cs_periodic_timer
    import cs_timer_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic       reset_in,
    input  wire logic       tick_in,
    input  wire logic [2:0] period_sel_in,
    input  wire logic [2:0] on_sel_in,
    output logic            running_out,
    output logic            on_window_out,
    output logic            on_start_out,
    output logic            on_end_out,
    output logic            idle_level_out,
    output logic            too_long_out
);
    logic [15:0] cnt_ff;
    logic [15:0] per_t;
    logic [15:0] on_t;
    logic        run;

    assign per_t          = period_ticks(period_sel_in);
    assign on_t           = on_ticks(on_sel_in);
    // timer starts as soon as a running on-time is chosen
    assign run            = (on_sel_in != ON_OFF_LOW) && (on_sel_in != ON_OFF_HIGH)
                            && (on_sel_in != 3'h7);
    assign running_out    = run;
    assign idle_level_out = (on_sel_in == ON_OFF_HIGH);
    assign too_long_out   = run && (on_t > per_t);
    assign on_window_out  = run && (cnt_ff < on_t);
    assign on_start_out   = run && tick_in && (cnt_ff == 16'h0000);
    assign on_end_out     = run && tick_in && (cnt_ff == on_t - 16'h0001);

    always_ff @(posedge clk_sys_in) begin
        // parked at the wrap point so the first on-time starts whole on a tick
        if (reset_in || !run) begin
            cnt_ff <= per_t - 16'h0001;
        end else if (tick_in) begin
            cnt_ff <= (cnt_ff >= per_t - 16'h0001) ? 16'h0000 : cnt_ff + 16'h0001;
        end
    end
endmodule // cs_periodic_timer

// ==== cyclic_sense_wake_timer.sv ====
// cyclic sense and cyclic wake timers with wake input sampling
`timescale 1ns/1ps
// Behaviour
// [RULE1] first sampled level becomes next reference
// [RULE2] level change wakes or interrupts by mode
// [RULE3] filter after on-time must see stable level
// [RULE4] change sets matching per-input wake flag
// [RULE5] level status updated only Normal/Stop
// [RULE6] Stop interrupts; Sleep goes Restart to Normal
// [RULE7] fail-safe drops switch, input static sensing
// [RULE8] switch faults disable that switch
// [RULE9] timers keep running after switch fault
// [RULE10] sleep with pending flag wakes, resets
// [RULE11] controller arms sense, clears flags first
// [RULE12] wake-source timer interrupts periodically
// [RULE13] controller disables, enables, then programs
// [RULE14] programmed on-time starts cyclic wake
// [RULE15] interrupt each on-start except first
// [RULE16] each timer mappable to any switch
// [RULE17] seven selectable periods
// [RULE18] five on-times plus two stopped levels
// [RULE19] on-time above period sets command error
// [RULE20] stopped level fixes switch output beforehand
// [RULE21] prescaler gives cycle-exact 0.1 ms ticks
module cyclic_sense_wake_timer
    import cs_timer_pkg::*;
#(
    parameter int TICK_CNT = TICK_CYCLES,
    parameter int FILT_CNT = FILTER_CYCLES
) (
    input  wire logic                  clk_sys_in,
    input  wire logic                  reset_in,
    input  wire cs_timer_pkg::dev_mode_e mode_in,
    input  wire logic                  sleep_req_in,
    input  wire logic [2:0]            timer_a_period_in,
    input  wire logic [2:0]            timer_a_on_in,
    input  wire logic [2:0]            timer_b_period_in,
    input  wire logic [2:0]            timer_b_on_in,
    input  wire logic [1:0]            timer_wake_enable_in,
    input  wire logic [NUM_SWITCH-1:0] map_timer_a_in,
    input  wire logic [NUM_SWITCH-1:0] map_timer_b_in,
    input  wire logic [NUM_SWITCH-1:0] switch_fault_in,
    input  wire logic [NUM_WAKE-1:0]   sense_enable_in,
    input  wire logic [NUM_WAKE-1:0]   sense_timer_b_in,
    input  wire logic [NUM_WAKE-1:0]   wake_input_pin_in,
    input  wire logic                  clear_wake_flags_in,
    input  wire logic                  clear_cmd_error_in,
    output logic [NUM_SWITCH-1:0]      high_side_switch_output_out,
    output logic [NUM_WAKE-1:0]        wake_flags_out,
    output logic [NUM_WAKE-1:0]        wake_level_status_out,
    output logic [NUM_WAKE-1:0]        static_sense_out,
    output logic                       interrupt_out,
    output logic                       wake_request_out,
    output logic                       reset_request_out,
    output logic                       cmd_error_out,
    output logic [1:0]                 timer_wake_flags_out
);
    logic [NUM_WAKE-1:0]   pin_meta_ff;
    logic [NUM_WAKE-1:0]   pin_sync_ff;
    logic [15:0]           pre_ff;
    logic                  tick_ff;
    logic [1:0]            run;
    logic [1:0]            on_win;
    logic [1:0]            on_start;
    logic [1:0]            on_end;
    logic [1:0]            idle_lvl;
    logic [1:0]            too_long;
    logic [1:0]            started_ff;
    logic [NUM_WAKE-1:0]   ref_ff;
    logic [NUM_WAKE-1:0]   ref_valid_ff;
    logic [NUM_WAKE-1:0]   filt_act_ff;
    logic [NUM_WAKE-1:0]   filt_lvl_ff;
    logic [NUM_WAKE-1:0]   filt_ok_ff;
    logic [15:0]           filt_cnt_ff [NUM_WAKE];
    logic [NUM_WAKE-1:0]   wake_hit;
    logic [NUM_WAKE-1:0]   flags_ff;
    logic [NUM_WAKE-1:0]   lvl_ff;
    logic [NUM_WAKE-1:0]   static_ff;
    logic [NUM_SWITCH-1:0] sw_off_ff;
    logic [NUM_SWITCH-1:0] hs_ff;
    logic [1:0]            twake_ff;
    logic [1:0]            twake_hit;
    logic                  int_ff;
    logic                  wake_ff;
    logic                  rst_ff;
    logic                  err_ff;
    logic                  fs_d_ff;
    logic                  norm_stop;
    logic                  fs_entry;
    logic [2:0]            on_a;
    logic [2:0]            on_b;

    assign on_a      = timer_a_on_in;
    assign on_b      = timer_b_on_in;
    assign norm_stop = (mode_in == MODE_NORMAL) || (mode_in == MODE_STOP);
    assign fs_entry  = (mode_in == MODE_FAILSAFE) && !fs_d_ff;

    // pins are asynchronous: two flops before use
    always_ff @(posedge clk_sys_in) begin
        pin_meta_ff <= wake_input_pin_in;
        pin_sync_ff <= pin_meta_ff;
    end

    // [RULE21] prescaler tick generation
    always_ff @(posedge clk_sys_in) begin
        if (reset_in || pre_ff == 16'(TICK_CNT - 1)) begin
            pre_ff  <= 16'h0000;
            tick_ff <= !reset_in;
        end else begin
            pre_ff  <= pre_ff + 16'h0001;
            tick_ff <= 1'b0;
        end
    end

    // [RULE17] [RULE18] two timers
    cs_periodic_timer u_timer_a (
        .clk_sys_in     (clk_sys_in),
        .reset_in       (reset_in),
        .tick_in        (tick_ff),
        .period_sel_in  (timer_a_period_in),
        .on_sel_in      (on_a),
        .running_out    (run[0]),
        .on_window_out  (on_win[0]),
        .on_start_out   (on_start[0]),
        .on_end_out     (on_end[0]),
        .idle_level_out (idle_lvl[0]),
        .too_long_out   (too_long[0])
    );

    cs_periodic_timer u_timer_b (
        .clk_sys_in     (clk_sys_in),
        .reset_in       (reset_in),
        .tick_in        (tick_ff),
        .period_sel_in  (timer_b_period_in),
        .on_sel_in      (on_b),
        .running_out    (run[1]),
        .on_window_out  (on_win[1]),
        .on_start_out   (on_start[1]),
        .on_end_out     (on_end[1]),
        .idle_level_out (idle_lvl[1]),
        .too_long_out   (too_long[1])
    );

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            fs_d_ff <= 1'b0;
        end else begin
            fs_d_ff <= (mode_in == MODE_FAILSAFE);
        end
    end

    // [RULE8] [RULE7] latched switch shutdown
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            sw_off_ff <= '0;
        end else if (fs_entry) begin
            sw_off_ff <= map_timer_a_in | map_timer_b_in | sw_off_ff;
        end else if (mode_in == MODE_NORMAL || mode_in == MODE_STOP
                     || mode_in == MODE_SLEEP) begin
            sw_off_ff <= sw_off_ff | switch_fault_in;
        end
    end

    // [RULE16] [RULE20] switch drive from mapped timers; [RULE9] timers unaffected
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            hs_ff <= '0;
        end else begin
            for (int s = 0; s < NUM_SWITCH; s++) begin
                hs_ff[s] <= !sw_off_ff[s] && !switch_fault_in[s] && (
                    (map_timer_a_in[s] && (run[0] ? on_win[0] : idle_lvl[0])) ||
                    (map_timer_b_in[s] && (run[1] ? on_win[1] : idle_lvl[1])));
            end
        end
    end

    // [RULE7] static sensing after fail-safe entry
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            static_ff <= '0;
        end else if (fs_entry) begin
            static_ff <= sense_enable_in;
        end
    end

    // per-input reference, filter and compare
    generate
        for (genvar w = 0; w < NUM_WAKE; w++) begin : g_wake
            logic cyc_end;
            logic sel_run;
            assign sel_run = sense_enable_in[w] && !static_ff[w]
                             && (sense_timer_b_in[w] ? run[1] : run[0]);
            assign cyc_end = sel_run && (sense_timer_b_in[w] ? on_end[1] : on_end[0]);

            // [RULE3] filter starts at end of on-time
            always_ff @(posedge clk_sys_in) begin
                if (reset_in || !sel_run) begin
                    filt_act_ff[w] <= 1'b0;
                    filt_lvl_ff[w] <= 1'b0;
                    filt_ok_ff[w]  <= 1'b0;
                    filt_cnt_ff[w] <= 16'h0000;
                end else if (cyc_end) begin
                    filt_act_ff[w] <= 1'b1;
                    filt_lvl_ff[w] <= pin_sync_ff[w];
                    filt_ok_ff[w]  <= 1'b1;
                    filt_cnt_ff[w] <= 16'h0000;
                end else if (filt_act_ff[w]) begin
                    if (pin_sync_ff[w] != filt_lvl_ff[w]) begin
                        filt_ok_ff[w] <= 1'b0;
                    end
                    if (filt_cnt_ff[w] == 16'(FILT_CNT - 1)) begin
                        filt_act_ff[w] <= 1'b0;
                    end else begin
                        filt_cnt_ff[w] <= filt_cnt_ff[w] + 16'h0001;
                    end
                end
            end

            // [RULE3] stable through filter and changed from reference
            assign wake_hit[w] = filt_act_ff[w] && (filt_cnt_ff[w] == 16'(FILT_CNT - 1))
                                 && filt_ok_ff[w] && (pin_sync_ff[w] == filt_lvl_ff[w])
                                 && ref_valid_ff[w] && (filt_lvl_ff[w] != ref_ff[w]);

            // [RULE1] sampled level kept as next reference
            always_ff @(posedge clk_sys_in) begin
                if (reset_in || !sel_run) begin
                    ref_ff[w]       <= 1'b0;
                    ref_valid_ff[w] <= 1'b0;
                end else if (wake_hit[w] || (filt_act_ff[w]
                             && filt_cnt_ff[w] == 16'(FILT_CNT - 1))) begin
                    ref_ff[w]       <= filt_lvl_ff[w];
                    ref_valid_ff[w] <= 1'b1;
                end
            end
        end
    endgenerate

    // [RULE4] wake flags, set wins over clear
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            flags_ff <= '0;
        end else begin
            flags_ff <= (clear_wake_flags_in ? '0 : flags_ff) | wake_hit;
        end
    end

    // [RULE5] level status only in Normal or Stop
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            lvl_ff <= '0;
        end else if (norm_stop) begin
            for (int w = 0; w < NUM_WAKE; w++) begin
                if (filt_act_ff[w] && filt_cnt_ff[w] == 16'(FILT_CNT - 1)) begin
                    lvl_ff[w] <= filt_lvl_ff[w];
                end
            end
        end
    end

    // [RULE14] [RULE15] skip the first on-start after timer start
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            started_ff <= 2'h0;
        end else begin
            for (int t = 0; t < 2; t++) begin
                if (!run[t]) begin
                    started_ff[t] <= 1'b0;
                end else if (on_start[t]) begin
                    started_ff[t] <= 1'b1;
                end
            end
        end
    end

    // [RULE12] timer wake flags
    assign twake_hit = on_start & started_ff & timer_wake_enable_in & run;
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            twake_ff <= 2'h0;
        end else begin
            twake_ff <= (clear_wake_flags_in ? 2'h0 : twake_ff) | twake_hit;
        end
    end

    // [RULE2] [RULE6] interrupt in Normal and Stop
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            int_ff <= 1'b0;
        end else begin
            int_ff <= norm_stop && ((|wake_hit) || (|twake_hit));
        end
    end

    // [RULE6] [RULE10] wake from Sleep through Restart
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            wake_ff <= 1'b0;
            rst_ff  <= 1'b0;
        end else begin
            wake_ff <= ((mode_in == MODE_SLEEP) && (|wake_hit))
                       || (sleep_req_in && (|flags_ff));
            rst_ff  <= sleep_req_in && (|flags_ff);
        end
    end

    // [RULE19] command error when on-time exceeds period
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            err_ff <= 1'b0;
        end else begin
            err_ff <= (err_ff && !clear_cmd_error_in) || (|too_long);
        end
    end

    assign high_side_switch_output_out = hs_ff;
    assign wake_flags_out              = flags_ff;
    assign wake_level_status_out       = lvl_ff;
    assign static_sense_out            = static_ff;
    assign interrupt_out               = int_ff;
    assign wake_request_out            = wake_ff;
    assign reset_request_out           = rst_ff;
    assign cmd_error_out               = err_ff;
    assign timer_wake_flags_out        = twake_ff;
endmodule // cyclic_sense_wake_timer

// ==== cs_timer_props.sv ====
// checker for the cyclic sense and wake timer ports
`timescale 1ns/1ps
module cs_timer_props (
    input wire logic                    clk_sys_in,
    input wire logic                    reset_in,
    input wire cs_timer_pkg::dev_mode_e mode_in,
    input wire logic                    sleep_req_in,
    input wire logic [3:0]              switch_fault_in,
    input wire logic [2:0]              sense_enable_in,
    input wire logic                    clear_wake_flags_in,
    input wire logic                    clear_cmd_error_in,
    input wire logic [3:0]              high_side_switch_output_out,
    input wire logic [2:0]              wake_flags_out,
    input wire logic [2:0]              wake_level_status_out,
    input wire logic [2:0]              static_sense_out,
    input wire logic                    interrupt_out,
    input wire logic                    wake_request_out,
    input wire logic                    reset_request_out,
    input wire logic                    cmd_error_out
);
    import cs_timer_pkg::*;
    logic [3:0] flt_ff;
    // switches faulted in normal, stop or sleep since reset
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) flt_ff <= '0;
        else if (mode_in < MODE_RESTART) flt_ff <= flt_ff | switch_fault_in;
    end
    function automatic logic awake(input dev_mode_e m);
        return (m == MODE_NORMAL) || (m == MODE_STOP);
    endfunction
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    fault_latch_a: assert property ((high_side_switch_output_out & flt_ff) == '0)
        else $error("faulted switch still on");
    fs_off_a: assert property ((mode_in == MODE_FAILSAFE) [*2] |=> high_side_switch_output_out == '0)
        else $error("switch on in fail-safe");
    fs_static_a: assert property ((mode_in != MODE_FAILSAFE ##1 mode_in == MODE_FAILSAFE) |=>
        (static_sense_out & $past(sense_enable_in)) == $past(sense_enable_in))
        else $error("input not moved to static sensing");
    int_pulse_a: assert property (interrupt_out |=> !interrupt_out)
        else $error("interrupt longer than one cycle");
    int_mode_a: assert property (interrupt_out |-> awake($past(mode_in)))
        else $error("interrupt outside normal or stop");
    wake_src_a: assert property (wake_request_out |->
        ($past(mode_in) == MODE_SLEEP) || $past(sleep_req_in))
        else $error("wake request without cause");
    pend_wake_a: assert property ((sleep_req_in && wake_flags_out != '0 && !clear_wake_flags_in)
        |-> ##[0:1] (wake_request_out && reset_request_out))
        else $error("pending flag did not wake");
    rst_pair_a: assert property (reset_request_out |-> wake_request_out)
        else $error("reset without wake");
    flag_keep_a: assert property (!clear_wake_flags_in |=>
        (wake_flags_out & $past(wake_flags_out)) == $past(wake_flags_out))
        else $error("wake flag lost without clear");
    err_keep_a: assert property (cmd_error_out && !clear_cmd_error_in |=> cmd_error_out)
        else $error("command error lost without clear");
    lvl_mode_a: assert property (!$stable(wake_level_status_out) |-> awake($past(mode_in)))
        else $error("level status moved outside normal or stop");
    cover property (interrupt_out);
    cover property (wake_request_out && $past(mode_in) == MODE_SLEEP);
    cover property (reset_request_out);
    cover property ($rose(cmd_error_out));
endmodule // cs_timer_props
bind cyclic_sense_wake_timer cs_timer_props cs_timer_props_i (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .mode_in(mode_in),
    .sleep_req_in(sleep_req_in), .switch_fault_in(switch_fault_in),
    .sense_enable_in(sense_enable_in), .clear_wake_flags_in(clear_wake_flags_in),
    .clear_cmd_error_in(clear_cmd_error_in),
    .high_side_switch_output_out(high_side_switch_output_out),
    .wake_flags_out(wake_flags_out), .wake_level_status_out(wake_level_status_out),
    .static_sense_out(static_sense_out), .interrupt_out(interrupt_out),
    .wake_request_out(wake_request_out), .reset_request_out(reset_request_out),
    .cmd_error_out(cmd_error_out));

// ==== cs_switch_model.sv ====
// switch contacts on the wake inputs, powered from the switch outputs
`timescale 1ns/1ps
module cs_switch_model #(
    parameter int HOLD = 12
) (
    input  wire logic       clk_sys_in,
    input  wire logic [2:0] hs_in,
    input  wire logic [2:0] contact_in,
    output logic      [2:0] pin_out
);
    int         hold [3] = '{0, 0, 0};
    logic [2:0] charge = 3'h0;
    // a powered contact shows at once; an unpowered line decays to its pull-down
    assign pin_out = (hs_in & contact_in) | (~hs_in & charge);
    always @(posedge clk_sys_in) begin
        for (int k = 0; k < 3; k++) begin
            if (hs_in[k]) begin
                hold[k] <= HOLD;
                charge[k] <= contact_in[k];
            end else if (hold[k] != 0) hold[k] <= hold[k] - 1;
            else charge[k] <= 1'b0;
        end
    end
endmodule // cs_switch_model

// ==== tb_top.sv ====
// self-checking bench for the cyclic sense and wake timers
`timescale 1ns/1ps
module tb_top;
    import cs_timer_pkg::*;
    localparam int TK = 4;
    // 0.1 ms ticks of periods 10..200 ms and of on-times 0.1, 0.3, 1 ms
    localparam int PER_T [5] = '{100, 200, 500, 1000, 2000};
    localparam int ON_T  [3] = '{1, 3, 10};
    logic       clk_sys_in = 1'b0;
    logic       reset_in   = 1'b1;
    dev_mode_e  mode_in    = MODE_NORMAL;
    logic       sleep_req  = 1'b0;
    logic [2:0] per_a = PER_10MS, on_a = ON_OFF_LOW, per_b = PER_10MS, on_b = ON_OFF_LOW;
    logic [1:0] wk_en = 2'h0, twf;
    logic [3:0] fault = 4'h0;
    logic [2:0] sen   = 3'h0;
    logic [2:0] contact = 3'h7;
    logic       clr_f = 1'b0, clr_e = 1'b0;
    logic [3:0] hs, hs_q;
    logic [2:0] pin, flags, lvl, stat;
    logic       irq, wreq, rreq, cerr;
    int         miscompares = 0, check_count = 0;
    int         n_int, n_wake, n_rst, cy, rise_t, per_seen, hi_len;
    int         rise [4];
    always #2.5 clk_sys_in = ~clk_sys_in;
    cyclic_sense_wake_timer #(.TICK_CNT(TK), .FILT_CNT(4)) cyclic_sense_wake_timer_i (
        .clk_sys_in(clk_sys_in), .reset_in(reset_in), .mode_in(mode_in),
        .sleep_req_in(sleep_req), .timer_a_period_in(per_a), .timer_a_on_in(on_a),
        .timer_b_period_in(per_b), .timer_b_on_in(on_b), .timer_wake_enable_in(wk_en),
        .map_timer_a_in(4'h5), .map_timer_b_in(4'hA), .switch_fault_in(fault),
        .sense_enable_in(sen), .sense_timer_b_in(3'h2), .wake_input_pin_in(pin),
        .clear_wake_flags_in(clr_f), .clear_cmd_error_in(clr_e),
        .high_side_switch_output_out(hs), .wake_flags_out(flags),
        .wake_level_status_out(lvl), .static_sense_out(stat), .interrupt_out(irq),
        .wake_request_out(wreq), .reset_request_out(rreq), .cmd_error_out(cerr),
        .timer_wake_flags_out(twf));
    cs_switch_model cs_switch_model_i (.clk_sys_in(clk_sys_in), .hs_in(hs[2:0]),
        .contact_in(contact), .pin_out(pin));
    always @(posedge clk_sys_in) begin
        cy++;
        n_int += irq;
        n_wake += wreq;
        n_rst += rreq;
        for (int k = 0; k < 4; k++) rise[k] += (hs[k] && !hs_q[k]);
        if (hs[0] && !hs_q[0]) begin
            per_seen = cy - rise_t;
            rise_t = cy;
        end
        if (!hs[0] && hs_q[0]) hi_len = cy - rise_t;
        hs_q = hs;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    task automatic zero();
        n_int = 0;
        n_wake = 0;
        n_rst = 0;
        for (int k = 0; k < 4; k++) rise[k] = 0;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // stop both timers, set period, set on-time last
    task automatic start(input logic [2:0] p, input logic [2:0] o);
        on_a = ON_OFF_LOW;
        on_b = ON_OFF_LOW;
        cyc(2);
        per_a = p;
        per_b = p;
        cyc(1);
        on_a = o;
        on_b = o;
    endtask
    task automatic wait_win(input int k);
        int i;
        for (i = 0; i < 900 && hs[k] !== 1'b1; i++) cyc(1);
        if (i == 900) begin
            miscompares++;
            print_verdict();
        end
        cyc(30);
    endtask
    task automatic do_reset();
        reset_in = 1'b1;
        cyc(10);
        reset_in = 1'b0;
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys_in);
        miscompares++;
        print_verdict();
    end
    initial begin
        do_reset();
        start(PER_10MS, ON_OFF_HIGH);
        cyc(5);
        check("idle_high", hs, 4'hF);
        start(PER_10MS, ON_OFF_LOW);
        cyc(5);
        check("idle_low", hs, 4'h0);
        for (int p = 0; p < 5; p++) begin
            start(3'(p), ON_0P1MS);
            cyc(PER_T[p] * TK * 2 + 40);
            check("period", per_seen, PER_T[p] * TK);
        end
        for (int o = 0; o < 3; o++) begin
            start(PER_10MS, 3'(o + 1));
            cyc(900);
            check("on_time", hi_len, ON_T[o] * TK);
        end
        $display("test timing done");
        // disable timers before enabling the wake source
        start(PER_10MS, ON_OFF_LOW);
        wk_en = 2'h1;
        start(PER_10MS, ON_0P1MS);
        zero();
        cyc(1000);
        check("wake_ints", n_int, 2);
        check("twake", twf, 2'h1);
        wk_en = 2'h0;
        $display("test cyclic wake done");
        // arm sensing in normal mode before low power
        sen = 3'h7;
        start(PER_10MS, ON_0P1MS);
        zero();
        cyc(900);
        check("first_ref", n_int, 0);
        check("lvl_init", lvl, 3'h7);
        for (int k = 0; k < 3; k++) begin
            clr_f = 1'b1;
            cyc(1);
            clr_f = 1'b0;
            mode_in = (k == 0) ? MODE_NORMAL : (k == 1) ? MODE_STOP : MODE_SLEEP;
            wait_win(k);
            zero();
            contact[k] = 1'b0;
            cyc(900);
            check("flags", flags, 3'h1 << k);
            check("ints", n_int, k < 2);
            check("wakes", n_wake, k == 2);
            check("lvl", lvl, (k == 0) ? 3'h6 : 3'h4);
        end
        mode_in = MODE_NORMAL;
        zero();
        sleep_req = 1'b1;
        cyc(1);
        sleep_req = 1'b0;
        cyc(4);
        check("pend_rst", n_rst, 1);
        check("pend_flag", flags, 3'h4);
        $display("test cyclic sense done");
        fault = 4'h1;
        cyc(1);
        fault = 4'h0;
        zero();
        cyc(900);
        check("fault_off", rise[0], 0);
        check("timer_runs", rise[2] > 1, 1);
        mode_in = MODE_FAILSAFE;
        cyc(5);
        check("fs_hs", hs, 4'h0);
        check("fs_static", stat, 3'h7);
        $display("test faults done");
        mode_in = MODE_NORMAL;
        do_reset();
        start(PER_10MS, ON_10MS);
        cyc(5);
        check("err_equal", cerr, 0);
        on_a = ON_20MS;
        cyc(5);
        check("err_long", cerr, 1);
        on_a = ON_0P1MS;
        clr_e = 1'b1;
        cyc(1);
        clr_e = 1'b0;
        cyc(2);
        check("err_clear", cerr, 0);
        $display("test command error done");
        print_verdict();
    end
endmodule // tb_top
